// ==== inc/pcgp_pkg.sv ====
`default_nettype none
package pcgp_pkg;
   // ----------------------------------------------------------------
   // Register window offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PMZ_NORM = 8'hb0;
   localparam logic [7:0] OFS_PMO_NORM = 8'hb1;
   localparam logic [7:0] OFS_VMC_NORM = 8'hc0;
   localparam logic [7:0] OFS_PAGE_NORM = 8'he0;
   localparam logic [7:0] OFS_PMZ_SWAP = 8'hb1;
   localparam logic [7:0] OFS_PMO_SWAP = 8'hb0;
   localparam logic [7:0] OFS_VMC_SWAP = 8'hc1;
   localparam logic [7:0] OFS_PAGE_SWAP = 8'he1;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_APD_ARM = 0;
   localparam int BIT_ALE_POL = 1;
   localparam int BIT_APD_EN = 2;
   localparam int BIT_FAST = 4;
   localparam int BIT_ACLK = 5;
   localparam int BIT_RCLK = 6;
   localparam int BIT_TCLK = 7;
   localparam int BIT_APD_SRC = 0;
   localparam int BIT_SLEEP_EN = 1;
   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_PAGE = 4'h0;
   localparam logic [3:0] APD_OVF_COUNT = 4'hf;
   localparam int IDLE_NS = 70;
   localparam int CLK_NS = 20;
   // Longest time rounds down
   localparam int IDLE_CYC_I = (IDLE_NS / CLK_NS) < 1 ? 1 : IDLE_NS / CLK_NS;
   localparam logic [2:0] IDLE_CYC = IDLE_CYC_I[2:0];
   localparam logic [2:0] WAKE_CYC = 3'h2;
endpackage
`default_nettype wire

// ==== design/pcgp_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Bit 4 sets array idle low-power mode
// - Clock pin feeds array, macrocells, counter
// - Bit 5 gates array clock off
// - Bit 6 gates macrocell clock off
// - Bit 7 gates timer clock off
// - Counter clock stops once power-down entered
// - Input buffer off: bits 5-7 plus overflow
// - Power-down leaves array run by fast bit
// - Sleep slows array, recovers after interval
// - Standby pin state: tristate only
// - Four page bits feed address decoder
// - Page loads D0-D3, reads back
// - Page works as plain storage register
// - Security bit refuses programmer reads
// - Select strobe covers 256-byte window
// - Normal offsets E0, C0, B0, B1
// - Swapped offsets E1, C1, B1, B0
// - Idle strobe overflows counter after 15
// - Reset clears all four registers
module pcgp_top (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic io_register_select_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] data_i,
   input wire logic swap_strap_i,
   input wire logic ale_i,
   input wire logic apd_alt_clk_i,
   input wire logic array_activity_i,
   input wire logic security_bit_i,
   input wire logic prog_read_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output logic [3:0] page_bits_o,
   output logic [7:0] volatile_memory_config_o,
   output logic array_clock_gate_o,
   output logic macrocell_clock_gate_o,
   output logic timer_clock_gate_o,
   output logic apd_clock_gate_o,
   output logic clock_input_pin_buf_en_o,
   output logic array_low_power_o,
   output logic array_slow_o,
   output logic standby_o,
   output logic sleep_o,
   output logic pins_tristate_o,
   output logic prog_read_ok_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] s_ale;
      logic [1:0] s_alt;
      logic [1:0] s_act;
      logic swap;
      logic [7:0] pmz;
      logic [7:0] pmo;
      logic [7:0] vmc;
      logic [3:0] page;
      logic [3:0] apd_cnt;
      logic ale_prev;
      logic alt_prev;
      logic [2:0] idle_cnt;
      logic [2:0] wake_cnt;
      logic sleep;
      logic slow;
      logic [7:0] rdata;
      logic oe;
      logic prog_ok;
      logic [3:0] gates;
      logic bufen;
      logic lowp;
      logic act_prev;
      logic stby;
   } pcgp_state_s;

   pcgp_state_s st_ff;
   pcgp_state_s nxt_st;
   logic ovf;
   logic ale_edge;
   logic apd_tick;

   // Offset decode, shared by read and write paths
   function automatic logic [2:0] pcgp_decode(input logic [7:0] a,
                                             input logic sw);
      logic [2:0] r;
      r = 3'h0;
      if (a == (sw ? pcgp_pkg::OFS_PMZ_SWAP : pcgp_pkg::OFS_PMZ_NORM)) begin
         r = 3'h4;
      end else if (a == (sw ? pcgp_pkg::OFS_PMO_SWAP
                            : pcgp_pkg::OFS_PMO_NORM)) begin
         r = 3'h5;
      end else if (a == (sw ? pcgp_pkg::OFS_VMC_SWAP
                            : pcgp_pkg::OFS_VMC_NORM)) begin
         r = 3'h6;
      end else if (a == (sw ? pcgp_pkg::OFS_PAGE_SWAP
                            : pcgp_pkg::OFS_PAGE_NORM)) begin
         r = 3'h7;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [2:0] d;
      logic apd_on;
      d = 3'h0;
      apd_on = 1'b0;
      nxt_st = st_ff;
      // Pins pass two flops before use
      nxt_st.s_ale = {st_ff.s_ale[0], ale_i};
      nxt_st.s_alt = {st_ff.s_alt[0], apd_alt_clk_i};
      nxt_st.s_act = {st_ff.s_act[0], array_activity_i};
      nxt_st.ale_prev = st_ff.s_ale[1];
      nxt_st.alt_prev = st_ff.s_alt[1];
      // Edge detectors read the second flop only, never the first
      nxt_st.act_prev = st_ff.s_act[1];
      // Strap sampled while the window is idle only, held while selected
      if (!io_register_select_i) begin
         nxt_st.swap = swap_strap_i;
      end
      // Window strobe gates all accesses; offset is the low byte
      d = io_register_select_i ? pcgp_decode(addr_i, st_ff.swap) : 3'h0;
      if (wr_i) begin
         case (d)
            3'h4: nxt_st.pmz = data_i;
            3'h5: nxt_st.pmo = data_i;
            3'h6: nxt_st.vmc = data_i;
            3'h7: nxt_st.page = data_i[3:0];
            default: ;
         endcase
      end
      case (d)
         3'h4: nxt_st.rdata = st_ff.pmz;
         3'h5: nxt_st.rdata = st_ff.pmo;
         3'h6: nxt_st.rdata = st_ff.vmc;
         3'h7: nxt_st.rdata = {4'h0, st_ff.page};
         default: nxt_st.rdata = 8'h00;
      endcase
      // Counter runs while the strobe rests at its power-down level
      apd_on = st_ff.pmz[pcgp_pkg::BIT_APD_EN] &&
               st_ff.pmz[pcgp_pkg::BIT_APD_ARM];
      if (!apd_on || ale_edge) begin
         nxt_st.apd_cnt = 4'h0;
      end else if (st_ff.s_ale[1] == st_ff.pmz[pcgp_pkg::BIT_ALE_POL] &&
                   apd_tick && !ovf) begin
         nxt_st.apd_cnt = st_ff.apd_cnt + 4'h1;
      end
      // Sleep needs overflow and its enable; slow path until wake done
      nxt_st.sleep = ovf && st_ff.pmo[pcgp_pkg::BIT_SLEEP_EN];
      if (st_ff.sleep && !nxt_st.sleep) begin
         nxt_st.wake_cnt = pcgp_pkg::WAKE_CYC;
      end else if (st_ff.wake_cnt != 3'h0) begin
         nxt_st.wake_cnt = st_ff.wake_cnt - 3'h1;
      end
      nxt_st.slow = nxt_st.sleep || nxt_st.wake_cnt != 3'h0;
      // Data port stays off in sleep; gated here so the pin is a flop
      nxt_st.oe = rd_i && (d != 3'h0) && !nxt_st.sleep;
      // Standby follows the overflow, kept in its own flop for the pins
      nxt_st.stby = ovf;
      // Idle timer for low-power array; power-down has no say
      if (st_ff.s_act[1] != st_ff.act_prev) begin
         nxt_st.idle_cnt = 3'h0;
      end else if (st_ff.idle_cnt != pcgp_pkg::IDLE_CYC) begin
         nxt_st.idle_cnt = st_ff.idle_cnt + 3'h1;
      end
      nxt_st.lowp = st_ff.pmz[pcgp_pkg::BIT_FAST] &&
                    nxt_st.idle_cnt == pcgp_pkg::IDLE_CYC;
      // One clock pin serves every consumer, each gated on its own
      nxt_st.gates = {!ovf,
                      !st_ff.pmz[pcgp_pkg::BIT_TCLK],
                      !st_ff.pmz[pcgp_pkg::BIT_RCLK],
                      !st_ff.pmz[pcgp_pkg::BIT_ACLK]};
      nxt_st.bufen = !(&st_ff.pmz[pcgp_pkg::BIT_TCLK:pcgp_pkg::BIT_ACLK]
                       && ovf);
      nxt_st.prog_ok = prog_read_i && !security_bit_i;
   end

   assign ovf = st_ff.apd_cnt == pcgp_pkg::APD_OVF_COUNT;
   assign ale_edge = st_ff.s_ale[1] != st_ff.ale_prev;
   // Counter clock: pin sampled on system clock, or system clock itself
   assign apd_tick = st_ff.pmo[pcgp_pkg::BIT_APD_SRC] ? 1'b1 :
                     (st_ff.s_alt[1] && !st_ff.alt_prev);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
         st_ff.gates <= 4'hf;
         st_ff.bufen <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops; the pin tristate output copies standby
   assign data_o = st_ff.rdata;
   assign data_oe_o = st_ff.oe;
   assign page_bits_o = st_ff.page;
   assign volatile_memory_config_o = st_ff.vmc;
   assign array_clock_gate_o = st_ff.gates[0];
   assign macrocell_clock_gate_o = st_ff.gates[1];
   assign timer_clock_gate_o = st_ff.gates[2];
   assign apd_clock_gate_o = st_ff.gates[3];
   assign clock_input_pin_buf_en_o = st_ff.bufen;
   assign array_low_power_o = st_ff.lowp;
   assign array_slow_o = st_ff.slow;
   assign standby_o = st_ff.stby;
   assign sleep_o = st_ff.sleep;
   assign pins_tristate_o = st_ff.stby;
   assign prog_read_ok_o = st_ff.prog_ok;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Register window: loads, readback and both offset maps
   a_page_readback: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (rd_i && io_register_select_i && !st_ff.swap &&
       addr_i == pcgp_pkg::OFS_PAGE_NORM && !wr_i)
      |=> data_o == {4'h0, $past(st_ff.page)})
      else $error("page readback wrong");
   a_page_load: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (wr_i && io_register_select_i && !st_ff.swap &&
       addr_i == pcgp_pkg::OFS_PAGE_NORM)
      |=> page_bits_o == $past(data_i[3:0]))
      else $error("page load wrong");
   a_page_keep: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      !(wr_i && io_register_select_i) |=> $stable(page_bits_o))
      else $error("page changed without write");
   a_norm_pmo: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (wr_i && io_register_select_i && !st_ff.swap &&
       addr_i == pcgp_pkg::OFS_PMO_NORM)
      |=> st_ff.pmo == $past(data_i))
      else $error("normal offset wrong");
   a_swap_zero: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (wr_i && io_register_select_i && st_ff.swap &&
       addr_i == pcgp_pkg::OFS_PMZ_SWAP)
      |=> ##1 array_clock_gate_o == !$past(data_i[5], 2))
      else $error("swapped offset wrong");
   a_swap_vmc: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (wr_i && io_register_select_i && st_ff.swap &&
       addr_i == pcgp_pkg::OFS_VMC_SWAP)
      |=> volatile_memory_config_o == $past(data_i))
      else $error("swapped config offset wrong");
   a_unmapped_oe: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (rd_i && !io_register_select_i) |=> !data_oe_o)
      else $error("read outside window");
   a_strap_hold: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      io_register_select_i |=> $stable(st_ff.swap))
      else $error("byte order moved mid access");
   // Clock gating and the input buffer
   a_aclk_gate: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      st_ff.pmz[5] |=> !array_clock_gate_o)
      else $error("array clock not gated");
   a_rclk_gate: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      $changed(st_ff.pmz[6])
      |=> macrocell_clock_gate_o == !$past(st_ff.pmz[6]))
      else $error("macrocell gate wrong");
   a_tclk_gate: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      st_ff.pmz[7] |=> !timer_clock_gate_o)
      else $error("timer clock not gated");
   a_buf_off: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      !clock_input_pin_buf_en_o |-> $past(ovf) && $past(&st_ff.pmz[7:5]))
      else $error("buffer off early");
   a_buf_on: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      !(&st_ff.pmz[7:5]) |=> clock_input_pin_buf_en_o)
      else $error("buffer off without all gates");
   a_apd_stop: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      ovf |=> !apd_clock_gate_o)
      else $error("apd clock not stopped");
   a_cnt_limit: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      ovf && !ale_edge && st_ff.pmz[2] && st_ff.pmz[0] |=> ovf)
      else $error("counter passed overflow");
   // Power modes, standby pins, reset and security
   a_fast_off: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      !st_ff.pmz[pcgp_pkg::BIT_FAST] |=> !array_low_power_o)
      else $error("low power without fast bit");
   a_idle_lowp: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      (st_ff.pmz[pcgp_pkg::BIT_FAST] && st_ff.s_act[1] == st_ff.act_prev &&
       st_ff.idle_cnt == pcgp_pkg::IDLE_CYC)
      |=> array_low_power_o)
      else $error("idle array not in low power");
   a_sleep_slow: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      sleep_o |-> array_slow_o)
      else $error("sleep without slow path");
   a_wake_recover: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      $fell(sleep_o)
      |-> array_slow_o ##1 array_slow_o ##1 !array_slow_o)
      else $error("wake recovery length wrong");
   a_sleep_no_oe: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      sleep_o |-> !data_oe_o)
      else $error("data port driven in sleep");
   a_stby_tri: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      pins_tristate_o == standby_o)
      else $error("standby pins not tristated");
   a_reset_clear: assert property (@(posedge clk_sys_i)
      $rose(reset_n_i) |-> st_ff.pmz == 8'h00 && st_ff.pmo == 8'h00 &&
      volatile_memory_config_o == 8'h00 && page_bits_o == 4'h0)
      else $error("registers not cleared");
   a_secure: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      security_bit_i |=> !prog_read_ok_o)
      else $error("secured read allowed");
   // Main scenarios worth seeing at least once
   c_sleep: cover property (@(posedge clk_sys_i) sleep_o);
   c_buf_off: cover property (@(posedge clk_sys_i) !clock_input_pin_buf_en_o);
   c_swap_wr: cover property (@(posedge clk_sys_i)
      wr_i && io_register_select_i && st_ff.swap);
   c_wake: cover property (@(posedge clk_sys_i) $fell(sleep_o));
   c_low_power: cover property (@(posedge clk_sys_i) array_low_power_o);
endmodule
`default_nettype wire

// ==== tb/pcgp_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcgp_host (
   input wire logic clk_sys_i,
   input wire logic [7:0] rdata_i,
   input wire logic rdata_oe_i,
   output logic sel_o,
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o
);
   // ----------------------------------------------------------------
   // Bus cycle
   // ----------------------------------------------------------------
   // Idle bus from time zero
   initial begin
      sel_o = 1'b0;
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   // Hold the request through the taking edge, then release
   task automatic access(input logic [7:0] a, input logic w,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic oe);
      @(posedge clk_sys_i);
      #1;
      sel_o = 1'b1;
      addr_o = a;
      wr_o = w;
      rd_o = ~w;
      wdata_o = d;
      @(posedge clk_sys_i);
      #1;
      q = rdata_i;
      oe = rdata_oe_i;
      sel_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      // Released lines must not keep showing the last value
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk, rst_n, sel, wr, rd, strap, ale, act, sec, prd, oe, ag, mg, tg;
   logic pg, bufen, lp, slow, sb, slp, tri3, pok, doe, alt;
   logic [7:0] addr, wd, dout, vmc, q;
   logic [3:0] page;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] ofs[4] = '{8'hb0, 8'hb1, 8'hc0, 8'he0};
   logic [7:0] pat[4] = '{8'h02, 8'h02, 8'ha5, 8'h3c};
   logic [7:0] msk[4] = '{8'hff, 8'hff, 8'hff, 8'h0f};
   pcgp_top pcgp_top_inst (.clk_sys_i(clk), .reset_n_i(rst_n),
      .io_register_select_i(sel), .addr_i(addr), .wr_i(wr), .rd_i(rd),
      .data_i(wd), .swap_strap_i(strap), .ale_i(ale),
      .apd_alt_clk_i(alt), .array_activity_i(act),
      .security_bit_i(sec), .prog_read_i(prd), .data_o(dout),
      .data_oe_o(doe), .page_bits_o(page),
      .volatile_memory_config_o(vmc), .array_clock_gate_o(ag),
      .macrocell_clock_gate_o(mg), .timer_clock_gate_o(tg),
      .apd_clock_gate_o(pg), .clock_input_pin_buf_en_o(bufen),
      .array_low_power_o(lp), .array_slow_o(slow), .standby_o(sb),
      .sleep_o(slp), .pins_tristate_o(tri3), .prog_read_ok_o(pok));
   pcgp_host pcgp_host_inst (.clk_sys_i(clk), .rdata_i(dout),
      .rdata_oe_i(doe), .sel_o(sel), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .wdata_o(wd));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] got,
                      input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      logic o;
      pcgp_host_inst.access(a, 1'b1, d, x, o);
   endtask
   task automatic rdr(input logic [7:0] a);
      pcgp_host_inst.access(a, 1'b0, 8'h00, q, oe);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, strap, ale, act, sec, prd, alt} = 7'h00;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdr(ofs[i]);
         chk("reset value", q, 8'h00);
      end
      chk("clock enables", {3'h0, ag, mg, tg, pg, bufen}, 8'h1f);
      // Each register in the normal map, page keeps D0-D3 only
      for (int i = 0; i < 4; i++) begin
         wrr(ofs[i], pat[i]);
         rdr(ofs[i]);
         chk("readback", q, pat[i] & msk[i]);
         chk("read enable", {7'h00, oe}, 8'h01);
      end
      chk("page out", {4'h0, page}, 8'h0c);
      chk("vm out", vmc, 8'ha5);
      wrr(8'he1, 8'h07);
      rdr(8'h42);
      chk("unmapped oe", {7'h00, oe}, 8'h00);
      settle(1);
      chk("page kept", {4'h0, page}, 8'h0c);
      for (int b = 5; b < 8; b++) begin
         wrr(8'hb0, 8'h01 << b);
         settle(2);
         chk("gates", {5'h00, tg, mg, ag}, 8'h07 ^ (8'h01 << (b - 5)));
      end
      // Fast-mode bit: idle inputs drop to low power, activity wakes
      wrr(8'hb0, 8'h10);
      settle(12);
      chk("low power", {7'h00, lp}, 8'h01);
      for (int i = 0; i < 6; i++) begin
         act = ~act;
         settle(1);
      end
      chk("active", {7'h00, lp}, 8'h00);
      // Swapped map, strap changed only while deselected
      wrr(8'hb0, 8'h00);
      strap = 1'b1;
      settle(2);
      wrr(8'hb1, 8'h20);
      settle(2);
      chk("swap gate", {7'h00, ag}, 8'h00);
      rdr(8'he1);
      chk("swap page", q, 8'h0c);
      rdr(8'hb0);
      chk("swap pm1", q, 8'h02);
      wrr(8'hb1, 8'h00);
      strap = 1'b0;
      settle(2);
      // Counter on system clock, sleep on, strobe parked high
      wrr(8'hb1, 8'h03);
      ale = 1'b1;
      wrr(8'hb0, 8'he7);
      settle(8);
      chk("early standby", {7'h00, sb}, 8'h00);
      settle(30);
      chk("standby", {6'h00, sb, slp}, 8'h03);
      chk("slow path", {7'h00, slow}, 8'h01);
      chk("stopped", {6'h00, pg, bufen}, 8'h00);
      chk("tristate", {7'h00, tri3}, 8'h01);
      for (int i = 0; i < 5; i++) begin
         ale = ~ale;
         settle(1);
      end
      settle(6);
      chk("woken", {5'h00, sb, slp, bufen}, 8'h01);
      chk("recovered", {7'h00, slow}, 8'h00);
      // Counter on the alternate pin: only that pin's edges count
      wrr(8'hb1, 8'h02);
      ale = 1'b1;
      settle(40);
      chk("alt idle", {7'h00, sb}, 8'h00);
      repeat (40) begin
         alt = ~alt;
         settle(1);
      end
      chk("alt standby", {7'h00, sb}, 8'h01);
      sec = 1'b1;
      prd = 1'b1;
      settle(3);
      chk("secured", {7'h00, pok}, 8'h00);
      sec = 1'b0;
      settle(3);
      chk("open", {7'h00, pok}, 8'h01);
      // Reset in mid-run clears the four registers again
      rst_n = 1'b0;
      settle(2);
      rst_n = 1'b1;
      rdr(8'hc0);
      chk("second reset", q, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
